//--- testbench.sv
// Self-checking bench for the video sync front end.
// Source model feeds the pins; registers reached by strobes.
`timescale 1ns/1ns
module testbench import vsd_pkg::*;;
    logic sys_clk = 1'b0;
    logic srst, reg_wr, reg_rd, vs, hs, fo, fo_oe_n, ho, ho_oe_n;
    logic encode_en, active_black, sync_tip_en, y_stb;
    logic [7:0] reg_addr, pix, cb, cr, y;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [31:0] p;
    logic [31:0] pats [3] = '{32'h00FFFFFF, 32'hFF030003, 32'hFF00FE00};
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    int n;
    int lat[$];
    vsd_top #(.FRAME_CYC(2000)) u_dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pix_i(pix), .field_parity_sync_i(vs), .hsync_i(hs), .field_parity_sync_o(fo),
        .field_parity_sync_oe_n(fo_oe_n), .hsync_o(ho), .hsync_oe_n(ho_oe_n),
        .encode_en(encode_en), .active_black(active_black), .sync_tip_en(sync_tip_en),
        .cb_o(cb), .cr_o(cr), .y_o(y), .y_stb(y_stb));
    vsd_src u_src (.sys_clk(sys_clk), .pix(pix), .vs(vs), .hs(hs));
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic setup(input logic [15:0] c);
        wr(VSD_ADDR_CTRL, c);
        wr(VSD_ADDR_CMD, 16'h0001);
        cyc(3);
    endtask
    // Counts cycles with line sync low over one line and a bit
    task automatic lows();
        n = 0;
        repeat (1400) begin
            cyc(1);
            n += int'(ho === 1'b0);
        end
    endtask
    function automatic logic [7:0] xy(input logic f, input logic v, input logic h);
        return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
    endfunction
    // Model of the range limiter
    function automatic int lim(input int b, input int hi, input bit full);
        if (full) return (b == 0) ? 1 : (b == 255) ? 254 : b;
        return (b < 16) ? 16 : (b > hi) ? hi : b;
    endfunction
    // Whole run needs about 9.5k cycles
    initial begin
        forever begin
            @(posedge sys_clk);
            cycles++;
            if (cycles == 30000) begin
                err_count++;
                stop_test();
            end
        end
    end
    initial begin
        srst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        wr(8'h0C, 16'hFFFF);
        rd(8'h0C);
        chk("unmapped", d, 16'h0000);
        rd(VSD_ADDR_CTRL);
        chk("ctrl", d, 16'h0000);
        for (int s = 0; s < 4; s++) begin
            u_src.sync(1'b0, 1'b0);
            setup(16'h0030 | 16'(s << 6));
            u_src.sync(1'b1, 1'b0);
            u_src.sync(1'b0, 1'b1);
            cyc(10);
            chk("enc_early", 16'(encode_en), 16'h0);
            chk("hs_oe_n", 16'(ho_oe_n), 16'h1);
            u_src.sync(1'b1, 1'b1);
            n = 0;
            while (encode_en !== 1'b1 && n < 30) begin
                cyc(1);
                n++;
            end
            lat.push_back(n);
            chk("enc", 16'(encode_en), 16'h1);
            chk("lat", 16'(n - lat[0]), 16'(s));
        end
        u_src.sync(1'b0, 1'b0);
        setup(16'h0001);
        u_src.sync(1'b1, 1'b0);
        cyc(10);
        chk("enc_rise", 16'(encode_en), 16'h0);
        u_src.sync(1'b0, 1'b0);
        cyc(6);
        chk("enc_fall", 16'(encode_en), 16'h1);
        setup(16'h0002);
        chk("pfs_oe_n", 16'(fo_oe_n), 16'h0);
        chk("blk", 16'(active_black), 16'h1);
        u_src.word(xy(1, 0, 1));
        cyc(20);
        u_src.word(xy(0, 0, 1));
        n = 0;
        while (encode_en !== 1'b1 && n < 30) begin
            cyc(1);
            n++;
        end
        chk("enc", 16'(encode_en), 16'h1);
        rd(VSD_ADDR_STAT);
        chk("lock", 16'(d[0]), 16'h1);
        cyc(4950);
        rd(VSD_ADDR_STAT);
        chk("lost2", 16'(d[1]), 16'h0);
        cyc(1100);
        rd(VSD_ADDR_STAT);
        chk("lost3", 16'(d[1]), 16'h1);
        chk("tip", 16'(sync_tip_en), 16'h0);
        lows();
        chk("hs_off", 16'(n), 16'h0);
        wr(VSD_ADDR_CTRL, 16'h000A);
        cyc(3);
        chk("tip_k", 16'(sync_tip_en), 16'h1);
        chk("blk_k", 16'(active_black), 16'h1);
        lows();
        chk("hs_k", 16'(n != 0), 16'h1);
        wr(VSD_ADDR_CTRL, 16'h0006);
        cyc(3);
        chk("blk_f", 16'(active_black), 16'h0);
        u_src.word(xy(1, 0, 1));
        cyc(20);
        u_src.word(xy(0, 0, 1));
        cyc(10);
        rd(VSD_ADDR_STAT);
        chk("relock", 16'(d[1:0]), 16'h1);
        u_src.word(8'hF0);
        cyc(8);
        u_src.word(xy(1, 1, 1));
        cyc(8);
        u_src.word(8'hF0);
        cyc(8);
        rd(VSD_ADDR_STAT);
        chk("herr1", 16'(d[2]), 16'h0);
        u_src.word(8'hF0);
        cyc(8);
        rd(VSD_ADDR_STAT);
        chk("herr2", 16'(d[2]), 16'h1);
        wr(VSD_ADDR_STAT, 16'h0004);
        rd(VSD_ADDR_STAT);
        chk("herr_clr", 16'(d[2]), 16'h0);
        for (int k = 0; k < 3; k++) begin
            setup({7'h00, k == 2, 8'h03});
            chk("oe", {14'h0, fo_oe_n, ho_oe_n}, 16'h0);
            u_src.word(xy(1, 0, 1));
            u_src.word(xy(0, 0, 1));
            u_src.word(xy(1, 0, 1));
            cyc(6);
            chk("fo", 16'(fo), 16'h1);
            p = pats[k];
            u_src.start_pat(xy(0, 0, 0), p);
            cyc(20);
            n = 0;
            repeat (40) begin
                cyc(1);
                n += int'(y_stb);
            end
            chk("ystb", 16'(n), 16'h14);
            chk("cb", 16'(cb), 16'(lim(p[31:24], 240, k == 2)));
            chk("y", 16'(y), 16'(lim(p[23:16], 235, k == 2)));
            chk("cr", 16'(cr), 16'(lim(p[15:8], 240, k == 2)));
            u_src.pat_on = 1'b0;
        end
        stop_test();
    end
endmodule

//--- vsd_demux.sv
// Splits the multiplexed byte stream into Cb, Y and Cr with range limiting.
// phase_start marks the byte that is a Cb sample; active marks active video.
`timescale 1ns/1ns
module vsd_demux import vsd_pkg::*; (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [7:0] din,
    input wire logic phase_start,
    input wire logic active,
    input wire logic full_range,
    output logic [7:0] cb_q,
    output logic [7:0] cr_q,
    output logic [7:0] y_q,
    output logic y_stb_q
);
    logic [1:0] phase_q, phase_d, role;
    logic [7:0] cb_d, cr_d, y_d;

    function automatic logic [7:0] limit(input logic [7:0] x, input logic [7:0] hi, input logic full,
                                         input logic act);
        if (full) begin
            // Extreme codes only replaced inside active video
            if (act && x == 8'h00) return VSD_SUB_LO; // [R19]
            if (act && x == 8'hFF) return VSD_SUB_HI; // [R19]
            return x;
        end
        if (x > hi) return hi; // [R17] [R18]
        if (x < VSD_C_LO) return VSD_C_LO; // [R17] [R18]
        return x;
    endfunction

    always_comb begin
        role = phase_start ? 2'h0 : phase_q; // [R4]
        phase_d = role + 2'h1;
        cb_d = cb_q;
        cr_d = cr_q;
        y_d = y_q;
        unique case (role) // [R16]
            2'h0: cb_d = limit(din, VSD_C_HI, full_range, active);
            2'h2: cr_d = limit(din, VSD_C_HI, full_range, active);
            default: y_d = limit(din, VSD_Y_HI, full_range, active);
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            phase_q <= 2'h0;
            cb_q <= VSD_C_LO;
            cr_q <= VSD_C_LO;
            y_q <= VSD_C_LO;
            y_stb_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            cb_q <= cb_d;
            cr_q <= cr_d;
            y_q <= y_d;
            y_stb_q <= role[0];
        end
    end

    property p_ylim;
        @(posedge sys_clk) disable iff (srst)
        y_stb_q && !$past(full_range) |-> y_q >= VSD_C_LO && y_q <= VSD_Y_HI;
    endproperty
    a_ylim: assert property (p_ylim) else $error("luma outside limited range"); // [R18]

    property p_clim;
        @(posedge sys_clk) disable iff (srst)
        !full_range && !phase_start && phase_q == 2'h2 |=> cr_q >= VSD_C_LO && cr_q <= VSD_C_HI;
    endproperty
    a_clim: assert property (p_clim) else $error("chroma outside limited range"); // [R17]

    property p_full;
        @(posedge sys_clk) disable iff (srst)
        full_range && active && phase_start && din == 8'hFF |=> cb_q == VSD_SUB_HI;
    endproperty
    a_full: assert property (p_full) else $error("code FF not replaced"); // [R19]

    c_full: cover property (@(posedge sys_clk) disable iff (srst) full_range && y_stb_q && y_q == VSD_SUB_LO);
endmodule

//--- vsd_pkg.sv
// Constants, register map and types shared by the video sync front end.
// Assumes a 20 MHz system clock; the cycle counts below derive from it.
package vsd_pkg;

    typedef enum logic [1:0] {
        VSD_M_VSYNC,
        VSD_M_FIELD,
        VSD_M_FRAME_WORD,
        VSD_M_LINE_WORD
    } vsd_mode_t;

    typedef enum logic [1:0] {VSD_IDLE, VSD_LOCKED, VSD_LOST} vsd_lock_t;

    localparam int VSD_DW = 16;
    localparam logic [7:0] VSD_ADDR_CTRL = 8'h00;
    localparam logic [7:0] VSD_ADDR_CMD = 8'h04;
    localparam logic [7:0] VSD_ADDR_STAT = 8'h08;

    localparam int VSD_CTRL_MODE = 0;
    localparam int VSD_CTRL_FREE = 2;
    localparam int VSD_CTRL_KEEP = 3;
    localparam int VSD_CTRL_POLV = 4;
    localparam int VSD_CTRL_POLH = 5;
    localparam int VSD_CTRL_SIA = 6;
    localparam int VSD_CTRL_FULL = 8;
    localparam int VSD_CTRL_W = 9;
    localparam logic [8:0] VSD_CTRL_RST = 9'h000;
    localparam int VSD_CMD_SOFT = 0;

    localparam int VSD_STAT_LOCK = 0;
    localparam int VSD_STAT_LOST = 1;
    localparam int VSD_STAT_HERR = 2;
    localparam int VSD_STAT_FIELD = 3;

    localparam int VSD_CLK_NS = 50;
    localparam int VSD_LINE_NS = 64000;
    localparam int VSD_LINE_CYC = VSD_LINE_NS / VSD_CLK_NS;
    localparam int VSD_HS_NS = 4700;
    localparam int VSD_HS_CYC = VSD_HS_NS / VSD_CLK_NS;
    localparam int VSD_FRAME_LINES = 625;
    localparam int VSD_FIELD_LINES = 313;
    localparam int VSD_MISS_MAX = 3;
    localparam int VSD_ERR_RUN = 2;

    localparam logic [7:0] VSD_TRS_ONE = 8'hFF;
    localparam logic [7:0] VSD_TRS_ZERO = 8'h00;
    localparam logic [7:0] VSD_C_LO = 8'h10;
    localparam logic [7:0] VSD_C_HI = 8'hF0;
    localparam logic [7:0] VSD_Y_HI = 8'hEB;
    localparam logic [7:0] VSD_SUB_LO = 8'h01;
    localparam logic [7:0] VSD_SUB_HI = 8'hFE;

endpackage

//--- vsd_src.sv
// Upstream source model: byte stream, frame sync and line sync pins.
// Steered by bench task calls; sends random fill when idle.
`timescale 1ns/1ns
module vsd_src (
    input wire logic sys_clk,
    output logic [7:0] pix,
    output logic vs,
    output logic hs
);
    integer seed = 1;
    logic busy = 1'b0;
    logic pat_on = 1'b0;
    logic [7:0] pat [4];
    int idx = 0;
    initial begin
        pix = 8'h01;
        vs = 1'b0;
        hs = 1'b0;
    end
    ////////////////////////////////////////
    // Fill never holds FF, so no false preamble
    always @(posedge sys_clk) begin
        if (pat_on) begin
            pix <= pat[idx];
            idx <= (idx + 1) % 4;
        end else if (!busy) begin
            pix <= 8'h01 + 8'(($random(seed) & 32'h7FFFFFFF) % 253);
        end
    end
    task automatic word(input logic [7:0] xy);
        logic [7:0] b [4];
        b = '{8'hFF, 8'h00, 8'h00, xy};
        busy = 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            pix <= b[i];
        end
        #1 busy = 1'b0;
    endtask
    task automatic start_pat(input logic [7:0] xy, input logic [31:0] p);
        word(xy);
        pat = '{p[31:24], p[23:16], p[15:8], p[7:0]};
        idx = 0;
        pat_on = 1'b1;
    endtask
    task automatic sync(input logic v, input logic h);
        @(posedge sys_clk);
        vs <= v;
        hs <= h;
    endtask
endmodule

//--- vsd_sync_dly.sv
// Programmable 0..3 cycle delay for the incoming sync levels.
// Input is already synchronised to sys_clk.
`timescale 1ns/1ns
module vsd_sync_dly import vsd_pkg::*; #(
    parameter int W = 2
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [W-1:0] din,
    input wire logic [1:0] sel,
    output logic [W-1:0] dout
);
    logic [W-1:0] tap_q [3];
    logic [W-1:0] tap_d [3];

    always_comb begin
        tap_d[0] = din;
        for (int i = 1; i < 3; i++) begin
            tap_d[i] = tap_q[i-1];
        end
        dout = (sel == 2'h0) ? din : tap_q[sel - 2'h1]; // [R5]
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            for (int i = 0; i < 3; i++) begin
                tap_q[i] <= '0;
            end
        end else begin
            tap_q <= tap_d;
        end
    end

    property p_dly2;
        @(posedge sys_clk) disable iff (srst)
        (sel == 2'h2) && $past(sel) == 2'h2 && $past(sel, 2) == 2'h2 |-> dout == $past(din, 2);
    endproperty
    a_dly2: assert property (p_dly2) else $error("sync delay of two cycles wrong"); // [R5]
endmodule

//--- vsd_top.sv
// Slave sync and input demultiplexer front end of a video encoder.
// Assumes pins are asynchronous to sys_clk; register port is synchronous.
// How it works
// R1: VSYNC edge plus HSYNC gives frame lock
// R2: Source supplies HSYNC alongside VSYNC
// R3: HSYNC only input, classifies field parity
// R4: First byte after active sync is Cb
// R5: Syncs delayed zero to three cycles
// R6: Field flag fall in EAV gives syncs
// R7: First flag fall starts sync and encoding
// R8: Three missed frame checks lose lock
// R9: Free-run keeps syncs, resyncs on flag
// R10: Sync-keep blackens line, keeps syncs
// R11: Otherwise black video, no syncs
// R12: Two successive word errors set status
// R13: Line-word mode drives syncs, line-locked
// R14: Early sync restarts, late sync waits
// R15: Only one frame sync edge counts
// R16: Stream split into Cb, Cr, Y
// R17: Chroma clamped to 16..240
// R18: Luma clamped to 16..235
// R19: Full range replaces only 00, FF
// R20: Timing words decoded from raw bytes
// R21: Preamble FF 00 00, fourth byte flags
// R22: Frame counter predicts next flag
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ns
module vsd_top import vsd_pkg::*; #(
    parameter int FRAME_CYC = VSD_LINE_CYC * VSD_FRAME_LINES
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [VSD_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [VSD_DW-1:0] reg_rdata,
    input wire logic [7:0] pix_i,
    input wire logic field_parity_sync_i,
    input wire logic hsync_i,
    output logic field_parity_sync_o,
    output logic field_parity_sync_oe_n,
    output logic hsync_o,
    output logic hsync_oe_n,
    output logic encode_en,
    output logic active_black,
    output logic sync_tip_en,
    output logic [7:0] cb_o,
    output logic [7:0] cr_o,
    output logic [7:0] y_o,
    output logic y_stb
);
    localparam int FCW = $clog2(FRAME_CYC);
    localparam logic [10:0] SAMP_LAST = 11'(VSD_LINE_CYC - 1);
    localparam logic [9:0] LINE_LAST = 10'(VSD_FRAME_LINES - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Pin capture and embedded word decode
    logic [9:0] meta_q, sync2_q;
    logic [1:0] dly_sync;
    logic [7:0] pix, xy;
    logic [7:0] w_q [3];
    logic [7:0] w_d [3];
    logic fs_prev_q, fs_prev_d, f_prev_q, f_prev_d, sav_q, sav_d, act_q, act_d;
    logic [1:0] err_run_q, err_run_d;
    logic trs, herr, f_bit, v_bit, h_bit, fs_edge, hs_act, f_fall, frame_ev, line_ev, herr_set;
    logic [VSD_CTRL_W-1:0] ctrl_q;
    vsd_mode_t mode;
    logic polv, polh, free_run, keep, word_mode;

    assign pix = sync2_q[9:2];
    assign mode = vsd_mode_t'(ctrl_q[VSD_CTRL_MODE +: 2]);
    assign free_run = ctrl_q[VSD_CTRL_FREE];
    assign keep = ctrl_q[VSD_CTRL_KEEP];
    assign polv = ctrl_q[VSD_CTRL_POLV];
    assign polh = ctrl_q[VSD_CTRL_POLH];
    assign word_mode = (mode == VSD_M_FRAME_WORD) || (mode == VSD_M_LINE_WORD);

    vsd_sync_dly #(.W(2)) u_dly (
        .sys_clk(sys_clk),
        .srst(srst),
        .din(sync2_q[1:0]),
        .sel(ctrl_q[VSD_CTRL_SIA +: 2]),
        .dout(dly_sync)
    );

    always_comb begin
        w_d[0] = pix;
        w_d[1] = w_q[0];
        w_d[2] = w_q[1];
        // Decoded from raw bytes, never from the limited stream
        xy = pix; // [R20]
        trs = w_q[2] == VSD_TRS_ONE && w_q[1] == VSD_TRS_ZERO && w_q[0] == VSD_TRS_ZERO; // [R21]
        f_bit = xy[6];
        v_bit = xy[5];
        h_bit = xy[4];
        herr = !xy[7] || xy[3:0] != {v_bit ^ h_bit, f_bit ^ h_bit, f_bit ^ v_bit, f_bit ^ v_bit ^ h_bit}; // [R12]
        err_run_d = err_run_q;
        if (trs) err_run_d = herr ? ((err_run_q == 2'(VSD_ERR_RUN)) ? err_run_q : err_run_q + 2'h1) : 2'h0;
        herr_set = trs && herr && err_run_q == 2'(VSD_ERR_RUN - 1); // [R12]
        f_fall = trs && !herr && h_bit && !f_bit && f_prev_q; // [R6]
        f_prev_d = (trs && !herr && h_bit) ? f_bit : f_prev_q;
        line_ev = trs && !herr && h_bit; // [R13]
        sav_d = trs && !herr && !h_bit;
        act_d = sav_d ? 1'b1 : (trs ? 1'b0 : act_q);
        fs_prev_d = dly_sync[1];
        fs_edge = (dly_sync[1] == polv) && (fs_prev_q != polv); // [R15]
        hs_act = dly_sync[0] == polh;
        unique case (mode)
            VSD_M_VSYNC: frame_ev = fs_edge && hs_act; // [R1] [R3]
            VSD_M_FIELD: frame_ev = fs_edge;
            default: frame_ev = f_fall; // [R6] [R13]
        endcase
    end

    always_ff @(posedge sys_clk) begin
        // First stage is read only by the second
        meta_q <= {pix_i, field_parity_sync_i, hsync_i};
        sync2_q <= meta_q;
        if (srst) begin
            for (int i = 0; i < 3; i++) begin
                w_q[i] <= 8'h00;
            end
            fs_prev_q <= 1'b0;
            f_prev_q <= 1'b0;
            sav_q <= 1'b0;
            act_q <= 1'b0;
            err_run_q <= 2'h0;
        end else begin
            w_q <= w_d;
            fs_prev_q <= fs_prev_d;
            f_prev_q <= f_prev_d;
            sav_q <= sav_d;
            act_q <= act_d;
            err_run_q <= err_run_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame lock and line timing
    vsd_lock_t st_q, st_d;
    logic [FCW-1:0] cnt_q, cnt_d;
    logic [1:0] miss_q, miss_d;
    logic [10:0] samp_q, samp_d;
    logic [9:0] line_q, line_d;
    logic field_q, field_d, run_q, run_d, restart, wrap, line_start, soft_q;

    always_comb begin
        st_d = st_q;
        miss_d = miss_q;
        run_d = run_q;
        restart = 1'b0;
        cnt_d = (cnt_q == '0) ? FCW'(FRAME_CYC - 1) : cnt_q - 1'b1; // [R22]
        unique case (st_q)
            VSD_IDLE: begin
                cnt_d = '0;
                if (frame_ev) begin
                    st_d = VSD_LOCKED; // [R7]
                    run_d = 1'b1;
                    restart = 1'b1;
                end
            end
            VSD_LOCKED: begin
                if (mode == VSD_M_LINE_WORD) begin
                    restart = frame_ev;
                end else if (cnt_q == '0) begin
                    if (frame_ev) begin
                        miss_d = 2'h0;
                        restart = 1'b1;
                    end else if (miss_q == 2'(VSD_MISS_MAX - 1)) begin
                        st_d = VSD_LOST; // [R8]
                        miss_d = 2'h0;
                    end else begin
                        miss_d = miss_q + 2'h1;
                    end
                end
            end
            VSD_LOST: begin
                if (frame_ev) begin
                    st_d = VSD_LOCKED; // [R9]
                    restart = 1'b1;
                end
            end
            default: st_d = VSD_IDLE;
        endcase
        if (restart) cnt_d = FCW'(FRAME_CYC - 1);
        wrap = (mode == VSD_M_LINE_WORD) ? line_ev : samp_q == SAMP_LAST;
        line_start = restart || (run_q && wrap);
        samp_d = samp_q;
        if (line_start) samp_d = 11'h000; // [R14]
        else if (run_q && samp_q != SAMP_LAST) samp_d = samp_q + 11'h001; // [R14]
        line_d = line_q;
        if (restart) line_d = 10'h000;
        else if (line_start) line_d = (line_q == LINE_LAST) ? 10'h000 : line_q + 10'h001;
        field_d = field_q;
        if (mode == VSD_M_LINE_WORD) field_d = line_ev ? f_bit : field_q; // [R13]
        else if (line_d == 10'h000) field_d = 1'b0;
        else if (line_d == 10'(VSD_FIELD_LINES)) field_d = 1'b1;
        if (soft_q) begin
            st_d = VSD_IDLE;
            run_d = 1'b0;
            miss_d = 2'h0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_q <= VSD_IDLE;
            cnt_q <= '0;
            miss_q <= 2'h0;
            samp_q <= 11'h000;
            line_q <= 10'h000;
            field_q <= 1'b0;
            run_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            miss_q <= miss_d;
            samp_q <= samp_d;
            line_q <= line_d;
            field_q <= field_d;
            run_q <= run_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register port and pin outputs
    logic [VSD_CTRL_W-1:0] ctrl_d;
    logic [VSD_DW-1:0] rdata_q, rdata_d;
    logic herr_q, herr_d, soft_d, lost_nf, sync_on;
    logic hs_q, hs_d, fs_q, fs_d, hs_oe_n_q, hs_oe_n_d, fs_oe_n_q, fs_oe_n_d;
    logic enc_q, blk_q, blk_d, tip_q;

    always_comb begin
        ctrl_d = ctrl_q;
        soft_d = 1'b0;
        herr_d = herr_q;
        if (reg_wr && reg_addr == VSD_ADDR_CTRL) ctrl_d = reg_wdata[VSD_CTRL_W-1:0];
        if (reg_wr && reg_addr == VSD_ADDR_CMD) soft_d = reg_wdata[VSD_CMD_SOFT];
        if (reg_wr && reg_addr == VSD_ADDR_STAT && reg_wdata[VSD_STAT_HERR]) herr_d = 1'b0;
        // Set after the status-write clear so a fresh error is not lost to it
        if (herr_set) herr_d = 1'b1; // [R12]
        if (soft_q) herr_d = 1'b0;
        rdata_d = '0;
        if (reg_rd && reg_addr == VSD_ADDR_CTRL) rdata_d[VSD_CTRL_W-1:0] = ctrl_q;
        if (reg_rd && reg_addr == VSD_ADDR_STAT) begin
            rdata_d[VSD_STAT_LOCK] = st_q == VSD_LOCKED;
            rdata_d[VSD_STAT_LOST] = st_q == VSD_LOST;
            rdata_d[VSD_STAT_HERR] = herr_q;
            rdata_d[VSD_STAT_FIELD] = field_q;
        end
        lost_nf = st_q == VSD_LOST && !free_run;
        sync_on = run_q && !(lost_nf && !keep); // [R9] [R10] [R11]
        hs_d = (sync_on && samp_q < 11'(VSD_HS_CYC)) ? polh : !polh;
        fs_d = sync_on && field_q;
        hs_oe_n_d = mode == VSD_M_VSYNC; // [R3]
        fs_oe_n_d = !word_mode; // [R6] [R13]
        blk_d = !run_q || lost_nf; // [R10] [R11]
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_q <= VSD_CTRL_RST;
            soft_q <= 1'b0;
            herr_q <= 1'b0;
            rdata_q <= '0;
            hs_q <= 1'b1;
            fs_q <= 1'b0;
            hs_oe_n_q <= 1'b1;
            fs_oe_n_q <= 1'b1;
            enc_q <= 1'b0;
            blk_q <= 1'b1;
            tip_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            soft_q <= soft_d;
            herr_q <= herr_d;
            rdata_q <= rdata_d;
            hs_q <= hs_d;
            fs_q <= fs_d;
            hs_oe_n_q <= hs_oe_n_d;
            fs_oe_n_q <= fs_oe_n_d;
            enc_q <= run_q;
            blk_q <= blk_d;
            tip_q <= sync_on;
        end
    end

    vsd_demux u_demux (
        .sys_clk(sys_clk),
        .srst(srst),
        .din(pix),
        .phase_start(word_mode ? sav_q : line_start), // [R4] [R16]
        .active(word_mode ? act_q : run_q),
        .full_range(ctrl_q[VSD_CTRL_FULL]),
        .cb_q(cb_o),
        .cr_q(cr_o),
        .y_q(y_o),
        .y_stb_q(y_stb)
    );

    assign reg_rdata = rdata_q;
    assign hsync_o = hs_q;
    assign hsync_oe_n = hs_oe_n_q;
    assign field_parity_sync_o = fs_q;
    assign field_parity_sync_oe_n = fs_oe_n_q;
    assign encode_en = enc_q;
    assign active_black = blk_q;
    assign sync_tip_en = tip_q;

    property p_lock;
        @(posedge sys_clk) disable iff (srst) st_q == VSD_IDLE && frame_ev && !soft_q |=> run_q ##1 enc_q;
    endproperty
    a_lock: assert property (p_lock) else $error("no start at first frame event"); // [R7]
    property p_lose;
        @(posedge sys_clk) disable iff (srst)
        st_q == VSD_LOCKED && mode != VSD_M_LINE_WORD && cnt_q == '0 && !frame_ev && miss_q == 2'h2 && !soft_q
        |=> st_q == VSD_LOST;
    endproperty
    a_lose: assert property (p_lose) else $error("lock not lost on third miss"); // [R8]
    property p_resync;
        @(posedge sys_clk) disable iff (srst) st_q == VSD_LOST && frame_ev && !soft_q |=> st_q == VSD_LOCKED;
    endproperty
    a_resync: assert property (p_resync) else $error("no resync after loss"); // [R9]
    property p_keep;
        @(posedge sys_clk) disable iff (srst) run_q && lost_nf && keep |=> blk_q && tip_q;
    endproperty
    a_keep: assert property (p_keep) else $error("sync-keep behaviour wrong"); // [R10]
    property p_mute;
        @(posedge sys_clk) disable iff (srst) lost_nf && !keep |=> hs_q == !$past(polh) && !fs_q && !tip_q;
    endproperty
    a_mute: assert property (p_mute) else $error("syncs not suppressed"); // [R11]
    property p_hsin;
        @(posedge sys_clk) disable iff (srst) mode == VSD_M_VSYNC [*2] |-> hsync_oe_n;
    endproperty
    a_hsin: assert property (p_hsin) else $error("hsync driven in vsync mode"); // [R3]
    property p_herr;
        @(posedge sys_clk) disable iff (srst) herr_set && !soft_q |=> herr_q;
    endproperty
    a_herr: assert property (p_herr) else $error("word error status not set"); // [R12]
    property p_early;
        @(posedge sys_clk) disable iff (srst) mode == VSD_M_LINE_WORD && run_q && line_ev |=> samp_q == 11'h000;
    endproperty
    a_early: assert property (p_early) else $error("early line sync not honoured"); // [R14]
    property p_late;
        @(posedge sys_clk) disable iff (srst)
        mode == VSD_M_LINE_WORD && run_q && samp_q == SAMP_LAST && !line_ev && !frame_ev |=> samp_q == SAMP_LAST;
    endproperty
    a_late: assert property (p_late) else $error("sample counter did not wait"); // [R14]
    property p_edge;
        @(posedge sys_clk) disable iff (srst) mode == VSD_M_FIELD && frame_ev
        |-> dly_sync[1] == polv && $past(dly_sync[1]) != polv;
    endproperty
    a_edge: assert property (p_edge) else $error("wrong frame sync edge used"); // [R15]

    c_lock: cover property (@(posedge sys_clk) disable iff (srst) st_q == VSD_IDLE ##1 st_q == VSD_LOCKED);
    c_lost: cover property (@(posedge sys_clk) disable iff (srst) st_q == VSD_LOST);
    c_resync: cover property (@(posedge sys_clk) disable iff (srst) st_q == VSD_LOST ##1 st_q == VSD_LOCKED);
    c_herr: cover property (@(posedge sys_clk) disable iff (srst) herr_set);
endmodule
